// ---- src/sensor_i2c_pkg.sv ----
package sensor_i2c_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ        = 20;
  localparam int RESET_WAIT_US  = 30;
  localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
  localparam int INT_PULSE_CYC  = 20;

  // ==========================================================================
  // Frame decoding
  localparam int         PTR_W        = 5;
  localparam int         FRM_W        = 2;
  localparam logic [7:0] RST_BYTE_ONE = 8'hff;
  localparam logic [7:0] RST_BYTE_ZRO = 8'h00;
  localparam logic [3:0] SINGLE_RISES = 4'ha;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_ADDR = 3'h1,
    PH_AACK = 3'h3,
    PH_TX   = 3'h2,
    PH_TACK = 3'h6,
    PH_RX   = 3'h7,
    PH_RACK = 3'h5,
    PH_SKIP = 3'h4
  } phase_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } bus_ev_t;

  typedef struct packed {
    logic collision_avoid_off;
    logic int_select;
    logic one_byte_read;
  } cfg_t;

  typedef struct packed {
    logic [FRM_W-1:0] conversion_frame_count;
    logic             powerdown_flag_hi;
    logic             powerdown_flag_lo;
  } diag_t;

  typedef struct packed {
    logic             strobe;
    logic [PTR_W-1:0] addr;
    logic [7:0]       data;
  } wr_t;

  typedef struct packed {
    phase_t           phase;
    logic             in_frame;
    logic [7:0]       shreg;
    logic [7:0]       txbyte;
    logic [3:0]       bitn;
    logic [3:0]       rises;
    logic [7:0]       first_byte;
    logic             is_read;
    logic             ptr_done;
    logic [PTR_W-1:0] ptr;
    logic             sda_oe;
    logic             scl_oe;
    logic             stretch;
    logic [1:0]       ones;
    logic [1:0]       zeros;
    logic [9:0]       rst_wait;
    logic             bus_reset;
    logic             int_pend;
    logic             int_act;
    logic [7:0]       int_cnt;
    logic             conv_q;
    diag_t            diag;
    wr_t              wr;
  } st_t;

  localparam logic [9:0] RESET_WAIT = 10'(RESET_WAIT_CYC);
  localparam logic [7:0] INT_LAST   = 8'(INT_PULSE_CYC - 1);

  // ==========================================================================
  // Mode decoding
  function automatic logic ca_active(input cfg_t c);
    return !c.collision_avoid_off && !c.int_select;
  endfunction

  function automatic logic stretch_active(input cfg_t c);
    return !c.collision_avoid_off && c.int_select;
  endfunction

endpackage

// ---- src/bus_watch.sv ----
`timescale 1ns/100ps
module bus_watch (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output sensor_i2c_pkg::bus_ev_t      ev
);

  typedef struct packed {
    logic                    scl_m;
    logic                    sda_m;
    logic                    scl_s;
    logic                    sda_s;
    logic                    scl_d;
    logic                    sda_d;
    sensor_i2c_pkg::bus_ev_t ev;
  } w_t;

  w_t w;
  w_t next_w;

  // ==========================================================================
  // Two-stage synchroniser, then edge and condition detection
  always_comb begin
    next_w             = w;
    next_w.scl_m       = scl_in;
    next_w.sda_m       = sda_in;
    next_w.scl_s       = w.scl_m;
    next_w.sda_s       = w.sda_m;
    next_w.scl_d       = w.scl_s;
    next_w.sda_d       = w.sda_s;
    next_w.ev.start    = w.scl_s && w.scl_d && w.sda_d && !w.sda_s;
    next_w.ev.stop     = w.scl_s && w.scl_d && !w.sda_d && w.sda_s;
    next_w.ev.scl_rise = w.scl_s && !w.scl_d;
    next_w.ev.scl_fall = !w.scl_s && w.scl_d;
    next_w.ev.sda      = w.sda_s;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w <= '{scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
             scl_d: 1'b1, sda_d: 1'b1, ev: '0};
    end else if (ce) begin
      w <= next_w;
    end
  end

  assign ev = w.ev;

endmodule

// ---- src/sensor_i2c_target.sv ----
`timescale 1ns/100ps
module sensor_i2c_target (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 ce,
  input  wire logic                                 scl_in,
  output logic                                      scl_out,
  output logic                                      scl_oe,
  input  wire logic                                 sda_in,
  output logic                                      sda_out,
  output logic                                      sda_oe,
  output logic                                      int_out,
  output logic                                      int_oe,
  input  wire logic [6:0]                           dev_addr,
  input  wire sensor_i2c_pkg::cfg_t                 cfg,
  input  wire logic                                 conv_busy,
  input  wire logic                                 conv_done,
  input  wire logic                                 supply_ok,
  input  wire logic                                 int_req,
  output logic [sensor_i2c_pkg::PTR_W-1:0]          rd_ptr,
  input  wire logic [7:0]                           rd_data,
  output sensor_i2c_pkg::wr_t                       wr,
  output sensor_i2c_pkg::diag_t                     diag,
  output logic                                      bus_reset,
  output logic                                      reset_busy
);

  sensor_i2c_pkg::bus_ev_t ev;
  sensor_i2c_pkg::st_t     s;
  sensor_i2c_pkg::st_t     next_s;
  logic                    ca_on;
  logic                    st_on;
  logic                    fire;

  bus_watch u_watch (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ev     (ev)
  );

  // First data bit drive enable and the remaining bits to shift
  function automatic logic [8:0] load_tx(input logic [7:0] d);
    return {!d[7], d[6:0], 1'b0};
  endfunction

  assign ca_on = sensor_i2c_pkg::ca_active(cfg);
  assign st_on = sensor_i2c_pkg::stretch_active(cfg);

  always_comb begin
    next_s               = s;
    fire                 = 1'b0;
    next_s.bus_reset     = 1'b0;
    next_s.wr.strobe     = 1'b0;

    // ========================================================================
    // Diagnostics
    next_s.conv_q = conv_busy;
    if (conv_busy && !s.conv_q) begin
      next_s.diag.powerdown_flag_lo = 1'b0;
      next_s.diag.powerdown_flag_hi = supply_ok;
    end else if (conv_busy && !supply_ok) begin
      next_s.diag.powerdown_flag_hi = 1'b0;
    end
    if (conv_done) begin
      next_s.diag.conversion_frame_count = s.diag.conversion_frame_count
                                           + 2'h1;
      next_s.diag.powerdown_flag_lo      = 1'b1;
    end

    // ========================================================================
    // Interrupt pulse
    if (s.int_act) begin
      if (ca_on && ev.start) begin
        next_s.int_act = 1'b0;
      end else if (s.int_cnt == sensor_i2c_pkg::INT_LAST) begin
        next_s.int_act  = 1'b0;
        next_s.int_pend = 1'b0;
      end else begin
        next_s.int_cnt = s.int_cnt + 8'h1;
      end
    end else if (s.int_pend && !(ca_on && (s.in_frame || ev.start))) begin
      next_s.int_act = 1'b1;
      next_s.int_cnt = 8'h00;
    end
    if (cfg.int_select) begin
      next_s.int_act  = 1'b0;
      next_s.int_pend = 1'b0;
    end else if (int_req) begin
      next_s.int_pend = 1'b1;
    end

    // ========================================================================
    // Bus protocol
    if (s.rst_wait != 10'h000) begin
      next_s.rst_wait = s.rst_wait - 10'h001;
    end else if (ev.start) begin
      next_s.in_frame = 1'b1;
      next_s.phase    = sensor_i2c_pkg::PH_ADDR;
      next_s.bitn     = 4'h0;
      next_s.rises    = 4'h0;
      next_s.sda_oe   = 1'b0;
      next_s.scl_oe   = 1'b0;
      next_s.stretch  = 1'b0;
      next_s.ptr_done = 1'b0;
    end else if (ev.stop) begin
      next_s.in_frame = 1'b0;
      next_s.phase    = sensor_i2c_pkg::PH_IDLE;
      next_s.sda_oe   = 1'b0;
      next_s.scl_oe   = 1'b0;
      next_s.stretch  = 1'b0;
      if (s.rises == sensor_i2c_pkg::SINGLE_RISES) begin
        case (s.first_byte)
          sensor_i2c_pkg::RST_BYTE_ONE: begin
            next_s.ones  = (s.ones == 2'h2) ? 2'h2 : s.ones + 2'h1;
            next_s.zeros = 2'h0;
          end
          sensor_i2c_pkg::RST_BYTE_ZRO: begin
            if (s.ones != 2'h0) begin
              next_s.zeros = s.zeros + 2'h1;
              fire         = (s.zeros == 2'h1);
            end
          end
          default: begin
            // A corrupted frame after two FF frames stands in for one 00 frame
            if (s.ones == 2'h2) begin
              next_s.zeros = s.zeros + 2'h1;
              fire         = (s.zeros == 2'h1);
            end
          end
        endcase
      end else if (s.rises > sensor_i2c_pkg::SINGLE_RISES) begin
        next_s.ones  = 2'h0;
        next_s.zeros = 2'h0;
      end
    end else begin
      if (ev.scl_rise && s.rises != 4'hf) begin
        next_s.rises = s.rises + 4'h1;
      end
      case (s.phase)
        sensor_i2c_pkg::PH_ADDR,
        sensor_i2c_pkg::PH_RX: begin
          if (ev.scl_rise) begin
            next_s.shreg = {s.shreg[6:0], ev.sda};
            next_s.bitn  = s.bitn + 4'h1;
          end else if (ev.scl_fall && s.bitn == sensor_i2c_pkg::BYTE_BITS) begin
            next_s.bitn = 4'h0;
            if (s.phase == sensor_i2c_pkg::PH_ADDR) begin
              next_s.first_byte = s.shreg;
              if (s.shreg[7:1] == dev_addr) begin
                next_s.is_read = s.shreg[0];
                next_s.phase   = sensor_i2c_pkg::PH_AACK;
                // One-byte reads start at pointer 0, set early so rd_data settles
                if (s.shreg[0] && cfg.one_byte_read) begin
                  next_s.ptr = '0;
                end
                if (s.shreg[0] && st_on && conv_busy) begin
                  next_s.scl_oe  = 1'b1;
                  next_s.stretch = 1'b1;
                end else begin
                  next_s.sda_oe = 1'b1;
                end
              end else begin
                next_s.phase = sensor_i2c_pkg::PH_SKIP;
              end
            end else begin
              next_s.phase  = sensor_i2c_pkg::PH_RACK;
              next_s.sda_oe = 1'b1;
              if (!s.ptr_done) begin
                next_s.ptr      = s.shreg[sensor_i2c_pkg::PTR_W-1:0];
                next_s.ptr_done = 1'b1;
              end else begin
                next_s.wr.strobe = 1'b1;
                next_s.wr.addr   = s.ptr;
                next_s.wr.data   = s.shreg;
                next_s.ptr       = s.ptr + 1'b1;
              end
            end
          end
        end
        sensor_i2c_pkg::PH_AACK: begin
          if (s.stretch) begin
            if (!conv_busy) begin
              next_s.stretch = 1'b0;
              next_s.sda_oe  = 1'b1;
            end
          end else if (s.scl_oe) begin
            next_s.scl_oe = 1'b0;
          end else if (ev.scl_fall) begin
            next_s.sda_oe = 1'b0;
            if (s.is_read && cfg.one_byte_read) begin
              {next_s.sda_oe, next_s.txbyte} = load_tx(rd_data);
              next_s.bitn                   = 4'h1;
              next_s.phase                  = sensor_i2c_pkg::PH_TX;
            end else begin
              next_s.phase = sensor_i2c_pkg::PH_RX;
            end
          end
        end
        sensor_i2c_pkg::PH_RACK: begin
          if (ev.scl_fall) begin
            next_s.sda_oe = 1'b0;
            if (s.is_read) begin
              {next_s.sda_oe, next_s.txbyte} = load_tx(rd_data);
              next_s.bitn                   = 4'h1;
              next_s.phase                  = sensor_i2c_pkg::PH_TX;
            end else begin
              next_s.phase = sensor_i2c_pkg::PH_RX;
            end
          end
        end
        sensor_i2c_pkg::PH_TX: begin
          if (ev.scl_fall) begin
            if (s.bitn == sensor_i2c_pkg::BYTE_BITS) begin
              next_s.sda_oe = 1'b0;
              next_s.ptr    = s.ptr + 1'b1;
              next_s.phase  = sensor_i2c_pkg::PH_TACK;
            end else begin
              next_s.sda_oe = !s.txbyte[7];
              next_s.txbyte = {s.txbyte[6:0], 1'b0};
              next_s.bitn   = s.bitn + 4'h1;
            end
          end
        end
        sensor_i2c_pkg::PH_TACK: begin
          if (ev.scl_rise && ev.sda) begin
            next_s.phase = sensor_i2c_pkg::PH_SKIP;
          end else if (ev.scl_fall) begin
            {next_s.sda_oe, next_s.txbyte} = load_tx(rd_data);
            next_s.bitn                   = 4'h1;
            next_s.phase                  = sensor_i2c_pkg::PH_TX;
          end
        end
        default: begin
        end
      endcase
    end

    // A taken reset sequence clears the target state except conv_q, and the bus protocol ignores every start and stop until rst_wait runs out
    if (fire) begin
      next_s           = '0;
      next_s.rst_wait  = sensor_i2c_pkg::RESET_WAIT;
      next_s.bus_reset = 1'b1;
      next_s.conv_q    = conv_busy;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign scl_out    = 1'b0;
  assign scl_oe     = s.scl_oe;
  assign sda_out    = 1'b0;
  assign sda_oe     = s.sda_oe;
  assign int_out    = 1'b0;
  assign int_oe     = s.int_act;
  assign rd_ptr     = s.ptr;
  assign wr         = s.wr;
  assign diag       = s.diag;
  assign bus_reset  = s.bus_reset;
  assign reset_busy = (s.rst_wait != 10'h000);

endmodule

// ---- verif/sensor_i2c_checker.sv ----
`timescale 1ns/100ps
module sensor_i2c_checker (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  input wire logic                  scl_in,
  input wire logic                  sda_in,
  input wire logic                  scl_oe,
  input wire logic                  sda_oe,
  input wire logic                  int_oe,
  input wire sensor_i2c_pkg::cfg_t  cfg,
  input wire logic                  conv_busy,
  input wire logic                  conv_done,
  input wire logic                  supply_ok,
  input wire sensor_i2c_pkg::diag_t diag,
  input wire logic                  bus_reset,
  input wire logic                  reset_busy
);
  logic       scl_q;
  logic       sda_q;
  logic       in_frm;
  logic [7:0] frm_q;
  logic [7:0] pulse_len;
  // ==========================================================================
  // Frame tracker on the wires, and interrupt pulse length
  always_ff @(posedge clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    frm_q <= {frm_q[6:0], in_frm};
    pulse_len <= int_oe ? pulse_len + 8'h01 : 8'h00;
    if (!rst_n) begin
      in_frm <= 1'b0;
    end else if (scl_in && scl_q && sda_q && !sda_in) begin
      in_frm <= 1'b1;
    end else if (scl_in && scl_q && !sda_q && sda_in) begin
      in_frm <= 1'b0;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_stretch_cause;
    conv_busy && !cfg.collision_avoid_off && cfg.int_select;
  endsequence
  sequence s_release;
    ##1 sda_oe ##1 !scl_oe;
  endsequence
  a_oe_reset: assert property (disable iff (1'b0) !rst_n && ce |=> !scl_oe && !sda_oe && !int_oe)
    else $error("outputs active after reset");
  a_stretch_cause: assert property ($rose(scl_oe) |-> s_stretch_cause)
    else $error("stretch without busy conversion in stretch mode");
  a_stretch_bound: assert property (scl_oe && !conv_busy |-> ##[1:2] !scl_oe)
    else $error("stretch held after conversion end");
  a_stretch_release: assert property ($fell(conv_busy) && scl_oe |-> s_release)
    else $error("ack and release order wrong");
  a_int_length: assert property ($fell(int_oe) && cfg.collision_avoid_off && !cfg.int_select
    |-> pulse_len == 8'(sensor_i2c_pkg::INT_PULSE_CYC))
    else $error("interrupt pulse length wrong");
  a_int_in_frame: assert property ($rose(int_oe) && !cfg.collision_avoid_off
    |-> !(in_frm && frm_q[7]))
    else $error("interrupt started inside a frame");
  a_int_abort: assert property ($rose(in_frm) && !cfg.collision_avoid_off && !cfg.int_select
    |-> ##3 !int_oe[*2])
    else $error("interrupt pulse not cut by start");
  a_int_select_off: assert property (cfg.int_select ##1 cfg.int_select |-> !int_oe)
    else $error("interrupt while select bit set");
  a_reset_clear: assert property (bus_reset |=> reset_busy && diag == '0)
    else $error("bus reset did not clear state");
  a_done_flag: assert property (conv_done |-> ##[1:2] diag.powerdown_flag_lo)
    else $error("finish flag not set");
  a_supply_flag: assert property (conv_busy && !supply_ok |-> ##[1:2] !diag.powerdown_flag_hi)
    else $error("supply flag not cleared");
endmodule

// ---- verif/i2c_host_model.sv ----
`timescale 1ns/100ps
module i2c_host_model (
  input  wire logic clk,
  input  wire logic dev_scl_oe,
  input  wire logic dev_sda_oe,
  output logic      scl,
  output logic      sda
);
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;
  int   stretch_cyc = 0;
  int   hang_cnt = 0;
  // Both lines have pull-ups, so a released line reads high
  assign scl = !(scl_lo || dev_scl_oe);
  assign sda = !(sda_lo || dev_sda_oe);
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Release SCL, then wait (bounded) while the device stretches it
  task automatic rise_scl();
    int n;
    n = 0;
    scl_lo = 1'b0;
    hc(1);
    while (!scl && n < 4000) begin
      hc(1);
      n++;
    end
    if (!scl) begin
      hang_cnt++;
    end
    stretch_cyc += n;
  endtask
  task automatic start();
    sda_lo = 1'b1;
    hc(4);
    scl_lo = 1'b1;
  endtask
  task automatic stop();
    hc(1);
    sda_lo = 1'b1;
    hc(4);
    rise_scl();
    hc(4);
    sda_lo = 1'b0;
    hc(8);
  endtask
  // Eight bits MSB first, then the ninth (acknowledge) bit
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic ak);
    logic [8:0] v;
    logic [8:0] r;
    v = {d, a};
    for (int i = 8; i >= 0; i--) begin
      hc(1);
      sda_lo = !v[i];
      hc(4);
      rise_scl();
      hc(1);
      r[i] = sda;
      hc(2);
      scl_lo = 1'b1;
    end
    q = r[8:1];
    ak = r[0];
  endtask
endmodule

// ---- verif/sensor_i2c_collision_stretch_reset_test.sv ----
`timescale 1ns/100ps
module sensor_i2c_collision_stretch_reset_test;
  localparam int P = sensor_i2c_pkg::INT_PULSE_CYC;
  logic                             clk = 1'b0;
  logic                             rst_n = 1'b0;
  logic [6:0]                       dev_addr = 7'h35;
  sensor_i2c_pkg::cfg_t             cfg = '0;
  logic                             conv_busy = 1'b0;
  logic                             conv_done = 1'b0;
  logic                             supply_ok = 1'b1;
  logic                             int_req = 1'b0;
  logic                             scl;
  logic                             sda;
  logic                             scl_oe;
  logic                             sda_oe;
  logic                             int_oe;
  logic                             bus_reset;
  logic                             reset_busy;
  logic [sensor_i2c_pkg::PTR_W-1:0] rd_ptr;
  logic [7:0]                       rd_data;
  sensor_i2c_pkg::wr_t              wr;
  sensor_i2c_pkg::wr_t              wr_last;
  sensor_i2c_pkg::diag_t            diag;
  logic [31:0]                      lfsr = 32'ha53d;
  logic [1:0]                       frm_exp = 2'h0;
  logic [7:0]                       q;
  logic                             ak;
  int                               error_cnt = 0;
  int                               check_count = 0;
  int                               rst_seen = 0;
  int                               int_seen = 0;
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [4:0] p);
    return {p, 3'h5} ^ 8'ha6;
  endfunction
  assign rd_data = exp_rd(rd_ptr);
  sensor_i2c_target u_sensor_i2c_target (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .int_out(), .int_oe(int_oe), .dev_addr(dev_addr), .cfg(cfg), .conv_busy(conv_busy),
    .conv_done(conv_done), .supply_ok(supply_ok), .int_req(int_req), .rd_ptr(rd_ptr),
    .rd_data(rd_data), .wr(wr), .diag(diag), .bus_reset(bus_reset), .reset_busy(reset_busy));
  i2c_host_model u_host (.clk(clk), .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe), .scl(scl),
    .sda(sda));
  // ==========================================================================
  // Clock, monitors and shared tasks
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bus_reset === 1'b1) begin
      rst_seen++;
    end
    if (int_oe === 1'b1) begin
      int_seen++;
    end
    if (wr.strobe === 1'b1) begin
      wr_last <= wr;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic pulse_int();
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    tick(30);
  endtask
  task automatic conv(input int n);
    conv_busy = 1'b1;
    tick(n);
    conv_busy = 1'b0;
    conv_done = 1'b1;
    tick(1);
    conv_done = 1'b0;
    frm_exp++;
  endtask
  task automatic frame1(input logic [7:0] b);
    u_host.start();
    u_host.xfer(b, 1'b1, q, ak);
    u_host.stop();
    tick(20);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("BAD t=%0t run limit reached", $time);
    final_report();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    tick(3);
    rst_n = 1'b1;
    tick(4);
    // Bus reset after power-up, plain, corrupted third or last frame
    for (int k = 0; k < 3; k++) begin
      conv(4);
      check(diag.conversion_frame_count, frm_exp);
      rst_seen = 0;
      frame1(8'hff);
      frame1(8'hff);
      frame1(k == 2 ? (lfsr[7:0] & 8'h7e) | 8'h02 : 8'h00);
      frame1(k == 1 ? (lfsr[7:0] & 8'h7e) | 8'h02 : 8'h00);
      check(rst_seen, 1);
      check(diag, '0);
      check(reset_busy, 1'b1);
      frm_exp = 2'h0;
      lfsr = next_rand(lfsr);
      tick(620);
      check(reset_busy, 1'b0);
    end
    $display("test bus_reset done");
    // Reconfigure after the reset: writes while a conversion runs
    cfg = 3'h2;
    for (int k = 0; k < 2; k++) begin
      conv_busy = 1'b1;
      u_host.stretch_cyc = 0;
      u_host.start();
      u_host.xfer({dev_addr, 1'b0}, 1'b1, q, ak);
      check(ak, 1'b0);
      u_host.xfer({3'h0, lfsr[4:0]}, 1'b1, q, ak);
      u_host.xfer(lfsr[15:8], 1'b1, q, ak);
      u_host.stop();
      check(wr_last, {1'b1, lfsr[4:0], lfsr[15:8]});
      check(u_host.stretch_cyc, 0);
      conv_busy = 1'b0;
      lfsr = next_rand(lfsr);
    end
    $display("test write done");
    // Stretched reads, two-byte then one-byte format
    for (int f = 0; f < 2; f++) begin
      cfg = {1'b0, 1'b1, f[0]};
      supply_ok = f[0];
      u_host.stretch_cyc = 0;
      fork
        conv(300);
        begin
          u_host.start();
          u_host.xfer({dev_addr, 1'b1}, 1'b1, q, ak);
          check(ak, 1'b0);
          if (f == 0) begin
            u_host.xfer({3'h0, lfsr[4:0]}, 1'b1, q, ak);
          end
          for (int i = 0; i < 2; i++) begin
            u_host.xfer(8'hff, i[0], q, ak);
            check(q, exp_rd((f ? 5'h00 : lfsr[4:0]) + i[4:0]));
          end
          u_host.stop();
        end
      join
      check(u_host.stretch_cyc > 150, 1'b1);
      check({diag.powerdown_flag_hi, diag.powerdown_flag_lo}, {f[0], 1'b1});
      check(diag.conversion_frame_count, frm_exp);
      supply_ok = 1'b1;
      lfsr = next_rand(lfsr);
    end
    $display("test stretch done");
    // Interrupt modes: avoid, plain, select; avoid mode is the preferred use
    for (int m = 0; m < 3; m++) begin
      cfg = {m == 1, m == 2, 1'b0};
      int_seen = 0;
      pulse_int();
      check(int_seen, m == 2 ? 0 : P);
      u_host.start();
      u_host.xfer({dev_addr ^ 7'h01, 1'b0}, 1'b1, q, ak);
      int_seen = 0;
      pulse_int();
      check(int_seen, m == 1 ? P : 0);
      int_seen = 0;
      u_host.stop();
      tick(30);
      check(int_seen, m == 0 ? P : 0);
    end
    // Pulse cut short by a start, issued again after the stop
    cfg = 3'h0;
    int_seen = 0;
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    tick(4);
    u_host.start();
    u_host.xfer({dev_addr ^ 7'h01, 1'b0}, 1'b1, q, ak);
    check(int_seen < P, 1'b1);
    int_seen = 0;
    u_host.stop();
    tick(30);
    check(int_seen, P);
    $display("test interrupt done");
    check(u_host.hang_cnt, 0);
    final_report();
  end
endmodule
bind sensor_i2c_target sensor_i2c_checker u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .int_oe(int_oe),
  .cfg(cfg), .conv_busy(conv_busy), .conv_done(conv_done), .supply_ok(supply_ok),
  .diag(diag), .bus_reset(bus_reset), .reset_busy(reset_busy));
